// ==== rtl/dma_channel_trigger_and_flags.sv ====
// Operation
// [RQ1] Pending flag high until buffered word stored
// [RQ2] Six-bit selector; four codes select nothing
// [RQ3] Selector routes one event source as trigger
// [RQ4] Access above high limit sets flag
// [RQ5] Access below low limit, above registers
// [RQ6] Limit check runs alongside, never blocks
// [RQ7] Completion flag reflects previous session outcome
// [RQ8] Halfway flag at counter midpoint
// [RQ9] Trigger during running operation sets overrun
// [RQ10] Halfway enable adds midpoint interrupt
// [RQ11] Software flag sets raise no interrupt
// [RQ12] Unused bits read zero; pending read-only
// [RQ13] Dummy mode adds write to source
// [RQ14] Channel runs only while enabled
// [RQ15] Software loads limits before enabling
// [RQ16] Flags sticky until cleared; zero after reset
// [RQ17] Interrupt request is single-cycle pulse
`timescale 1ns/1ps
module dma_channel_trigger_and_flags
   import dma_trig_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [63:0] trigger_events,
   input  wire logic [15:0] mem_rdata,
   output mem_req_t         mem_req,
   output logic             irq_request,
   output logic             done_pulse,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   chan_state_t state;                 // Channel sequencer
   logic [15:0] source_pointer;        // Source address
   logic [15:0] destination_pointer;   // Destination address
   logic [15:0] transaction_counter;   // Remaining operations
   logic [15:0] start_count;           // Count loaded by software
   logic [15:0] high_address_limit;    // Upper boundary
   logic [15:0] low_address_limit;     // Lower boundary
   logic [15:0] buffer_word;           // Staged data word
   logic        buffered_write_pending;
   logic [5:0]  trigger_selector;
   logic        high_limit_flag, low_limit_flag, completion_flag;
   logic        halfway_flag, overrun_flag, halfway_interrupt_enable;
   logic        channel_enable, dummy_write_mode;
   logic [4:0]  int_status, int_mask;  // Sticky events and their mask
   logic        aw_held, w_held;       // Write channel halves taken
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;              // Register write this cycle
   logic        trig, op_end, done_evt, half_evt, ovr_evt, high_evt, low_evt;
   logic [15:0] next_count;
   logic [15:0] irq_view;              // Read view of the interrupt register

   ////////////////////////////////////////////////////////////////////////////
   // Functions
   // Merge the two low byte lanes of a write into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // A code selects a source unless it is one of the unimplemented ones
   function automatic logic sel_valid(input logic [5:0] sel);
      sel_valid = (sel != SEL_NONE_LO) && (sel < SEL_NONE_HI);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Trigger routing and sequencer events
   assign trig       = sel_valid(trigger_selector) && trigger_events[trigger_selector];   // RQ2 RQ3
   assign op_end     = (state == ST_WRITE && !dummy_write_mode) || state == ST_DUMMY;
   assign next_count = transaction_counter - 16'h0001;
   assign done_evt   = op_end && channel_enable && next_count == RESET_ZERO;
   assign half_evt   = op_end && channel_enable && next_count == (start_count >> 1) && next_count != RESET_ZERO;
   assign ovr_evt    = trig && channel_enable && state != ST_IDLE;                        // RQ9
   assign do_write   = aw_held && w_held && !s_axi_bvalid;

   // Current bus access, offered while the limit check runs beside it
   always_comb begin
      mem_req.valid = state != ST_IDLE;
      mem_req.write = state == ST_WRITE || state == ST_DUMMY;
      mem_req.addr  = (state == ST_WRITE) ? destination_pointer : source_pointer;
      mem_req.data  = buffer_word;
   end

   // Limit comparison after the fact; the access is never held back
   assign high_evt = mem_req.valid && (mem_req.addr > high_address_limit || mem_req.addr > RAM_TOP);   // RQ4 RQ6
   assign low_evt  = mem_req.valid && mem_req.addr < low_address_limit && mem_req.addr > SFR_TOP;     // RQ5 RQ6

   // Pulses come only from hardware events, never from register writes
   assign irq_request = done_evt || (half_evt && halfway_interrupt_enable);                // RQ10 RQ11 RQ17
   assign done_pulse  = done_evt;
   assign irq         = |(int_status & int_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Channel sequencer: read source, write destination, optional dummy write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
      end else if (!channel_enable) begin
         state <= ST_IDLE;                                                               // RQ14
      end else begin
         case (state)
            ST_IDLE:  if (trig && transaction_counter != RESET_ZERO) begin
                         state <= ST_READ;
                      end
            ST_READ:  state <= ST_WRITE;
            ST_WRITE: state <= dummy_write_mode ? ST_DUMMY : ST_IDLE;                      // RQ13
            ST_DUMMY: state <= ST_IDLE;
            default:  state <= ST_IDLE;
         endcase
      end
   end

   // Staged word and its pending flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buffer_word            <= RESET_ZERO;
         buffered_write_pending <= 1'b0;
      end else if (state == ST_READ && channel_enable) begin
         buffer_word            <= mem_rdata;
         buffered_write_pending <= 1'b1;                                                 // RQ1
      end else if (op_end || !channel_enable) begin
         buffered_write_pending <= 1'b0;                                                 // RQ1
      end
   end

   // Pointers and counter: software loads, hardware steps after each operation unless a load lands in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         source_pointer      <= RESET_ZERO;
         destination_pointer <= RESET_ZERO;
         transaction_counter <= RESET_ZERO;
         start_count         <= RESET_ZERO;
      end else if (do_write && aw_addr == OFS_SOURCE) begin
         source_pointer <= merge16(source_pointer, w_data, w_strb);
      end else if (do_write && aw_addr == OFS_DEST) begin
         destination_pointer <= merge16(destination_pointer, w_data, w_strb);
      end else if (do_write && aw_addr == OFS_COUNT) begin
         transaction_counter <= merge16(transaction_counter, w_data, w_strb);
         start_count         <= merge16(transaction_counter, w_data, w_strb);
      end else if (op_end && channel_enable) begin
         source_pointer      <= source_pointer + PTR_STEP;
         destination_pointer <= destination_pointer + PTR_STEP;
         transaction_counter <= next_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trigger_selector         <= 6'h00;
         halfway_interrupt_enable <= 1'b0;
         channel_enable           <= 1'b0;
         dummy_write_mode         <= 1'b0;
         high_address_limit       <= RESET_ZERO;
         low_address_limit        <= RESET_ZERO;
         int_mask                 <= 5'h00;
      end else if (do_write) begin
         case (aw_addr)
            OFS_IRQ_TRIGGER: begin
               if (w_strb[1]) trigger_selector <= w_data[BIT_SEL_LO +: 6];                 // RQ2
               if (w_strb[0]) halfway_interrupt_enable <= w_data[BIT_HALF_EN];
            end
            OFS_CHAN_CTRL: begin
               if (w_strb[0]) channel_enable <= w_data[BIT_CHAN_EN];                       // RQ14
               if (w_strb[1]) dummy_write_mode <= w_data[BIT_DUMMY];
            end
            OFS_HIGH_LIMIT: high_address_limit <= merge16(high_address_limit, w_data, w_strb);
            OFS_LOW_LIMIT:  low_address_limit <= merge16(low_address_limit, w_data, w_strb);
            OFS_INT_MASK:   if (w_strb[0]) int_mask <= w_data[4:0];
            default: ;
         endcase
      end
   end

   // Sticky channel flags; software writes store, hardware sets win
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {high_limit_flag, low_limit_flag, completion_flag, halfway_flag, overrun_flag} <= 5'h00;   // RQ16
      end else begin
         if (do_write && aw_addr == OFS_IRQ_TRIGGER && w_strb[0]) begin
            {high_limit_flag, low_limit_flag, completion_flag, halfway_flag, overrun_flag} <=
               w_data[BIT_HIGH:BIT_OVERRUN] | {high_evt, low_evt, done_evt, half_evt, ovr_evt};   // RQ11 RQ16
         end else begin
            if (high_evt) high_limit_flag <= 1'b1;                                        // RQ4
            if (low_evt) low_limit_flag <= 1'b1;                                          // RQ5
            if (done_evt) completion_flag <= 1'b1;                                        // RQ7
            if (half_evt) halfway_flag <= 1'b1;                                           // RQ8
            if (ovr_evt) overrun_flag <= 1'b1;                                            // RQ9
         end
      end
   end

   // Event status for the interrupt output, write one to clear, set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_status <= 5'h00;
      end else begin
         int_status <= (int_status & ~((do_write && aw_addr == OFS_INT_STATUS && w_strb[0]) ? w_data[4:0] : 5'h00))
                       | {low_evt, high_evt, ovr_evt, half_evt, done_evt};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channels, address and data taken in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr > OFS_INT_MASK) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read view: unused bits zero, pending flag visible but never written
   assign irq_view = {buffered_write_pending, 1'b0, trigger_selector, high_limit_flag, low_limit_flag,
                      completion_flag, halfway_flag, overrun_flag, 2'b00, halfway_interrupt_enable};   // RQ12

   // AXI4-Lite read channel, answer one cycle after the address
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            OFS_IRQ_TRIGGER: s_axi_rdata <= {16'h0000, irq_view};
            OFS_CHAN_CTRL:   s_axi_rdata <= {21'h000000, dummy_write_mode, 9'h000, channel_enable};
            OFS_SOURCE:      s_axi_rdata <= {16'h0000, source_pointer};
            OFS_DEST:        s_axi_rdata <= {16'h0000, destination_pointer};
            OFS_COUNT:       s_axi_rdata <= {16'h0000, transaction_counter};
            OFS_HIGH_LIMIT:  s_axi_rdata <= {16'h0000, high_address_limit};
            OFS_LOW_LIMIT:   s_axi_rdata <= {16'h0000, low_address_limit};
            OFS_INT_STATUS:  s_axi_rdata <= {27'h0000000, int_status};
            OFS_INT_MASK:    s_axi_rdata <= {27'h0000000, int_mask};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_PENDING_IDLE: assert property (state == ST_IDLE |-> !buffered_write_pending) // RQ1
      else $error("pending flag set while idle");
   AST_SEL_NONE: assert property (state == ST_IDLE && (trigger_selector == SEL_NONE_LO // RQ2
                                  || trigger_selector >= SEL_NONE_HI) |=> state == ST_IDLE)
      else $error("unimplemented selector code started an operation");
   AST_START: assert property (state == ST_IDLE && trig && channel_enable && transaction_counter != 16'h0000 // RQ3
                               |=> state == ST_READ ##1 state == ST_WRITE)
      else $error("selected trigger did not start an operation");
   AST_HIGH_FLAG: assert property (mem_req.valid && mem_req.addr > high_address_limit |=> high_limit_flag) // RQ4
      else $error("high limit violation not flagged");
   AST_LOW_FLAG: assert property (mem_req.valid && mem_req.addr < low_address_limit && mem_req.addr > 16'h07FF // RQ5
                                  |=> low_limit_flag)
      else $error("low limit violation not flagged");
   AST_NO_BLOCK: assert property (state == ST_READ && channel_enable |=> mem_req.valid && mem_req.write) // RQ6
      else $error("access held back by limit check");
   AST_DONE: assert property (done_evt |=> completion_flag && state == ST_IDLE) // RQ7
      else $error("completion not flagged");
   AST_HALF: assert property (half_evt |=> halfway_flag) else $error("halfway point not flagged"); // RQ8
   AST_OVERRUN: assert property (trig && channel_enable && state != ST_IDLE |=> overrun_flag) // RQ9
      else $error("overrun not flagged");
   AST_HALF_MASKED: assert property (half_evt && !halfway_interrupt_enable |-> !irq_request) // RQ10
      else $error("halfway interrupt while disabled");
   AST_SW_NO_IRQ: assert property (irq_request |-> op_end) else $error("interrupt without a hardware event"); // RQ11
   AST_RESERVED: assert property (irq_view[14] == 1'b0 && irq_view[2:1] == 2'b00) // RQ12
      else $error("reserved bits read nonzero");
   AST_DUMMY: assert property (state == ST_WRITE && dummy_write_mode && channel_enable // RQ13
                               |=> state == ST_DUMMY && mem_req.addr == $past(source_pointer))
      else $error("dummy write missing");
   AST_DISABLED: assert property (!channel_enable |=> state == ST_IDLE) else $error("active while disabled"); // RQ14
   AST_PULSE: assert property (irq_request |=> !irq_request) else $error("interrupt request too long"); // RQ17

   COV_DONE: cover property (done_evt);
   COV_DUMMY: cover property (state == ST_DUMMY);
   COV_OVERRUN: cover property (ovr_evt);
   COV_HALF_IRQ: cover property (half_evt && halfway_interrupt_enable);

endmodule

// ==== rtl/dma_trig_pkg.sv ====
package dma_trig_pkg;

   //////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_IRQ_TRIGGER = 8'h00;   // Channel interrupt and trigger register
   localparam logic [7:0] OFS_CHAN_CTRL   = 8'h04;   // Channel enable and dummy write mode
   localparam logic [7:0] OFS_SOURCE      = 8'h08;   // Source pointer
   localparam logic [7:0] OFS_DEST        = 8'h0C;   // Destination pointer
   localparam logic [7:0] OFS_COUNT       = 8'h10;   // Transaction counter
   localparam logic [7:0] OFS_HIGH_LIMIT  = 8'h14;   // High address limit
   localparam logic [7:0] OFS_LOW_LIMIT   = 8'h18;   // Low address limit
   localparam logic [7:0] OFS_INT_STATUS  = 8'h1C;   // Sticky event status, write one to clear
   localparam logic [7:0] OFS_INT_MASK    = 8'h20;   // Event mask

   //////////////////////////////////////////////////////////////////////////
   // Field positions of the interrupt and trigger register
   localparam int BIT_PENDING  = 15;   // Buffered write pending, read only
   localparam int BIT_SEL_LO   = 8;    // Trigger selector low bit
   localparam int BIT_HIGH     = 7;    // High limit flag
   localparam int BIT_LOW      = 6;    // Low limit flag
   localparam int BIT_DONE     = 5;    // Completion flag
   localparam int BIT_HALF     = 4;    // Halfway flag
   localparam int BIT_OVERRUN  = 3;    // Overrun flag
   localparam int BIT_HALF_EN  = 0;    // Halfway interrupt enable
   // Control register fields
   localparam int BIT_CHAN_EN  = 0;    // Channel enable
   localparam int BIT_DUMMY    = 10;   // Dummy write mode
   // Event status and mask layout
   localparam int EV_DONE = 0, EV_HALF = 1, EV_OVERRUN = 2, EV_HIGH = 3, EV_LOW = 4;

   //////////////////////////////////////////////////////////////////////////
   // Selector codes and memory map
   localparam logic [5:0]  SEL_NONE_LO  = 6'h00;     // Unimplemented code
   localparam logic [5:0]  SEL_NONE_HI  = 6'h3D;     // First of the unimplemented top codes
   localparam logic [15:0] SFR_TOP      = 16'h07FF;  // Last address of the register space
   localparam logic [15:0] RAM_TOP      = 16'hFFFF;  // Top of data RAM, plain default
   localparam logic [15:0] RESET_ZERO   = 16'h0000;  // Reset value of every 16-bit register
   localparam logic [15:0] PTR_STEP     = 16'h0002;  // Word step of the pointers
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;

   // One-hot channel states
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_READ  = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_DUMMY = 4'b1000
   } chan_state_t;

   // One access of the channel on the data bus
   typedef struct packed {
      logic        valid;   // Access under way this cycle
      logic        write;   // Write when high, read when low
      logic [15:0] addr;    // Byte address
      logic [15:0] data;    // Write data
   } mem_req_t;

endpackage

// ==== test/trigger_source.sv ====
`timescale 1ns/1ps
module trigger_source
   import dma_trig_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       fire,
   input  wire logic [5:0] code,
   input  wire mem_req_t   mem_req,
   output logic [63:0]     trigger_events,
   output logic [15:0]     mem_rdata
);
   logic [15:0] last;   // Word driven in the previous cycle
   // Event pulse on the chosen source line, lasting as many cycles as fire is high
   always_ff @(posedge aclk) begin
      trigger_events <= (fire && aresetn) ? (64'h1 << code) : 64'h0;
   end
   // Data only during a read; otherwise the inverse, so a stale sample shows
   assign mem_rdata = (mem_req.valid && !mem_req.write) ? (mem_req.addr ^ 16'hA5C3) : ~last;
   always_ff @(posedge aclk) begin
      last <= aresetn ? mem_rdata : 16'h0000;
   end
endmodule

// ==== test/dma_channel_trigger_and_flags_test.sv ====
`timescale 1ns/1ps
module dma_channel_trigger_and_flags_test
   import dma_trig_pkg::*;
;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire;
   logic        awready, wready, bvalid, arready, rvalid, irq_request, done_pulse, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rnd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, wresp;
   logic [5:0]  code;
   logic [63:0] trigger_events;
   logic [15:0] mem_rdata, last_wr, last_wd;
   mem_req_t    mem_req;
   int          mismatches, compares, cyc, wr_cnt, irq_cnt, done_cnt;

   always #5 aclk = ~aclk;

   trigger_source src (.aclk(aclk), .aresetn(aresetn), .fire(fire), .code(code), .mem_req(mem_req),
      .trigger_events(trigger_events), .mem_rdata(mem_rdata));
   dma_channel_trigger_and_flags uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .trigger_events(trigger_events), .mem_rdata(mem_rdata), .mem_req(mem_req),
      .irq_request(irq_request), .done_pulse(done_pulse), .irq(irq));

   ///////////////////////////////////////////////////////////////////////////
   // Monitor: counts memory writes and interrupt pulses, cuts a hang short
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (mem_req.valid === 1'b1 && mem_req.write === 1'b1) begin
         wr_cnt  <= wr_cnt + 1;
         last_wr <= mem_req.addr;
         last_wd <= mem_req.data;
      end
      if (irq_request === 1'b1) irq_cnt <= irq_cnt + 1;
      if (done_pulse === 1'b1) done_cnt <= done_cnt + 1;
      if (cyc == 5000) begin
         mismatches = mismatches + 1;
         final_report();
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Interrupt pulses per session: midpoint only when enabled and reachable
   function automatic int exp_irq(input int n, input logic he);
      return (he && n / 2 != 0) ? 2 : 1;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= {rnd[1:0], 2'b11};
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      wresp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // Raise the event for len consecutive cycles, then let the channel finish
   task automatic trig(input logic [5:0] c, input int len);
      @(posedge aclk);
      code <= c; fire <= 1'b1;
      repeat (len) @(posedge aclk);
      fire <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask

   ///////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [5:0]  c;
      logic [15:0] a;
      int          n, w0, i0, d0;
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire} = 8'h00;
      {awaddr, araddr, wdata, wstrb, code} = 58'h0;
      {mismatches, compares, cyc, wr_cnt, irq_cnt, done_cnt} = '0;
      rnd = 32'h00014C78;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_IRQ_TRIGGER, d, r); chk(d, 32'h0);
      rd(8'h24, d, r); chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(8'h24, 32'h0); chk({30'h0, wresp}, {30'h0, RESP_SLVERR});
      wr(OFS_IRQ_TRIGGER, 32'h0000FFFF);
      rd(OFS_IRQ_TRIGGER, d, r); chk(d, 32'h00003FF9);
      chk(irq_cnt, 32'h0);
      for (int k = 0; k < 2; k++) begin
         rnd = lfsr(rnd);
         c = 6'(1 + rnd[7:0] % 60);
         n = 2 + rnd[10:8] % 5;
         wr(OFS_CHAN_CTRL, 32'h0);
         wr(OFS_HIGH_LIMIT, 32'h0000FFF0); wr(OFS_LOW_LIMIT, 32'h00000800);
         wr(OFS_SOURCE, 32'h00001000); wr(OFS_DEST, 32'h00002000); wr(OFS_COUNT, 32'(n));
         wr(OFS_IRQ_TRIGGER, {18'h0, c, 7'h0, k[0]}); wr(OFS_INT_MASK, 32'h1F);
         chk({30'h0, wresp}, {30'h0, RESP_OKAY});
         w0 = wr_cnt; i0 = irq_cnt; d0 = done_cnt;
         trig(c, 1); chk(wr_cnt - w0, 32'h0);
         wr(OFS_CHAN_CTRL, 32'h00000401);
         trig(c ^ 6'h01, 1); chk(wr_cnt - w0, 32'h0);
         for (int j = 0; j < n; j++) trig(c, 1);
         chk(wr_cnt - w0, 32'(2 * n));
         chk(irq_cnt - i0, 32'(exp_irq(n, k[0])));
         chk(done_cnt - d0, 32'h1);
         a = 16'h1000 + 16'(2 * n - 2);
         chk({16'h0, last_wr}, {16'h0, a});
         chk({16'h0, last_wd}, {16'h0, a ^ 16'hA5C3});
         rd(OFS_IRQ_TRIGGER, d, r); chk(d, {18'h0, c, 8'b0011_0000 | 8'(k[0])});
         chk({31'h0, irq}, 32'h1);
         wr(OFS_INT_STATUS, 32'h1F); chk({31'h0, irq}, 32'h0);
      end
      // Limits violated by both pointers, plus a trigger during a running operation
      wr(OFS_IRQ_TRIGGER, 32'h0); wr(OFS_HIGH_LIMIT, 32'h00008000); wr(OFS_LOW_LIMIT, 32'h00001000);
      wr(OFS_SOURCE, 32'h00000900); wr(OFS_DEST, 32'h0000FFF8); wr(OFS_COUNT, 32'h4);
      wr(OFS_CHAN_CTRL, 32'h00000001);
      w0 = wr_cnt;
      trig(6'h00, 1); chk(wr_cnt - w0, 32'h0);
      wr(OFS_IRQ_TRIGGER, {18'h0, c, 8'h00});
      trig(c, 2); chk(wr_cnt - w0, 32'h1); chk({16'h0, last_wr}, 32'h0000FFF8);
      chk({16'h0, last_wd}, {16'h0, 16'h0900 ^ 16'hA5C3});
      rd(OFS_IRQ_TRIGGER, d, r); chk(d, {18'h0, c, 8'hC8});
      chk({31'h0, irq}, 32'h1);
      wr(OFS_INT_MASK, 32'h0); chk({31'h0, irq}, 32'h0);
      final_report();
   end
endmodule
